// File: inc/elm_params.svh
// Constants for the link monitor: register offsets, field positions,
// reset values and index assignments. Definitions only.
`ifndef ELM_PARAMS_SVH
`define ELM_PARAMS_SVH

`define ELM_ADDR_W       4
`define ELM_OFS_LINK     4'h0
`define ELM_OFS_MASK     4'h4
`define ELM_OFS_EVST     4'h8
`define ELM_OFS_EVDT     4'hc

`define ELM_NLINK        5
`define ELM_NPIN         6
`define ELM_STN_ONE      0
`define ELM_STN_TWO_FIB  1
`define ELM_STN_TWO_CU   2
`define ELM_PROC_BUS     3
`define ELM_FRONT        4
`define ELM_PIN_FRONT_CU 4
`define ELM_PIN_ONBOARD  5

`define ELM_PIN_RST      6'h00
`define ELM_LINK_RST     5'h00
`define ELM_MASK_RST     5'h00
`define ELM_WORD_RST     32'h0000_0000

`define ELM_EVST_CNT_LSB 0
`define ELM_EVST_CNT_MSB 3
`define ELM_EVST_OVF_BIT 8
`define ELM_EVDT_LNK_LSB 0
`define ELM_EVDT_LNK_MSB 2
`define ELM_EVDT_ON_BIT  3
`define ELM_EVDT_VLD_BIT 31
`define ELM_BE_MASK      0
`define ELM_BE_OVF       1

`define ELM_LOG_DEPTH    4'h8
`define ELM_LOG_AW       3
`define ELM_CNT_W        4
`define ELM_PTR_ONE      3'h1
`define ELM_CNT_ONE      4'h1
`define ELM_CNT_ZERO     4'h0
`define ELM_PTR_ZERO     3'h0

`endif

// File: inc/elm_pkg.sv
// Types shared by the link monitor and its event log.
// Assumes elm_params.svh for the widths.
`include "elm_params.svh"
package elm_pkg;
  typedef logic [`ELM_NLINK-1:0] elm_links_t;
  typedef logic [2:0]            elm_idx_t;
  typedef logic [`ELM_CNT_W-1:0] elm_cnt_t;
  typedef struct packed {
    logic     on;
    elm_idx_t link;
  } elm_evt_s;
  typedef enum logic {
    ELM_BUS_IDLE,
    ELM_BUS_ACK
  } elm_bus_e;
endpackage

// File: inc/elm_evt_if.sv
// Carrier between the monitor and its event list.
// Assumes elm_pkg is compiled first.
`timescale 1ns/1ps
interface elm_evt_if;
  logic              push;
  elm_pkg::elm_evt_s push_code;
  logic              pop;
  logic              ovf_clr;
  elm_pkg::elm_evt_s head;
  logic              empty;
  logic              full;
  elm_pkg::elm_cnt_t count;
  logic              ovf;
  modport prod (output push, push_code, pop, ovf_clr,
                input  head, empty, full, count, ovf);
  modport log  (input  push, push_code, pop, ovf_clr,
                output head, empty, full, count, ovf);
endinterface

// File: hw/elm_event_log.sv
// Event list: a small circular store of link on/off events.
// Assumes one push and one pop at most per enabled cycle.
`timescale 1ns/1ps
`include "elm_params.svh"
module elm_event_log (
  input  wire logic clk_i,  // System clock
  input  wire logic rst_i,  // Synchronous reset, active high
  input  wire logic ce_i,   // Clock enable, freezes state when low
  elm_evt_if.log    evt     // Push and pop side
);
  elm_pkg::elm_evt_s             mem_r [`ELM_LOG_DEPTH];
  logic [`ELM_LOG_AW-1:0]        wr_ptr_r;
  logic [`ELM_LOG_AW-1:0]        rd_ptr_r;
  elm_pkg::elm_cnt_t             count_r;
  logic                          ovf_r;
  logic                          do_push;
  logic                          do_pop;

  assign evt.full  = (count_r == `ELM_LOG_DEPTH);
  assign evt.empty = (count_r == `ELM_CNT_ZERO);
  assign evt.count = count_r;
  assign evt.ovf   = ovf_r;
  assign evt.head  = mem_r[rd_ptr_r];
  // A full list keeps its oldest entries; the newest one is lost
  assign do_push   = evt.push && !evt.full;
  assign do_pop    = evt.pop && !evt.empty;

  always_ff @(posedge clk_i) begin
    if (ce_i && do_push) begin
      mem_r[wr_ptr_r] <= evt.push_code;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_r <= `ELM_PTR_ZERO;
      rd_ptr_r <= `ELM_PTR_ZERO;
      count_r  <= `ELM_CNT_ZERO;
    end else if (ce_i) begin
      if (do_push) begin
        wr_ptr_r <= wr_ptr_r + `ELM_PTR_ONE;
      end
      if (do_pop) begin
        rd_ptr_r <= rd_ptr_r + `ELM_PTR_ONE;
      end
      if (do_push && !do_pop) begin
        count_r <= count_r + `ELM_CNT_ONE;
      end else if (do_pop && !do_push) begin
        count_r <= count_r - `ELM_CNT_ONE;
      end
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_r <= 1'b0;
    end else if (ce_i) begin
      if (evt.push && evt.full) begin
        ovf_r <= 1'b1;
      end else if (evt.ovf_clr) begin
        ovf_r <= 1'b0;
      end
    end
  end
endmodule

// File: hw/elm_link_monitor.sv
// Link monitor: turns port link indications into five status outputs,
// an event list and forwarded events, with an Avalon-MM register slave.
// Assumes link pins are asynchronous levels from the port PHYs.
//
// How it works
// - upper fiber link drives station bus one
// - middle fiber link drives station bus two fiber
// - rear copper link drives station bus two copper
// - lower fiber link drives process bus
// - front copper or onboard port drives front
// - log each link's latest pending change while the list has room, else set overflow; forward when mask enabled
// - status register reads the five link outputs
// - mask register is the only setting; five link outputs plus forwarded events
`timescale 1ns/1ps
`include "elm_params.svh"
module elm_link_monitor (
  input  wire logic        clk_i,                         // System clock, 20 MHz
  input  wire logic        rst_i,                         // Synchronous reset, active high
  input  wire logic        ce_i,                          // Clock enable
  input  wire logic        fiber_upper_link_i,            // Upper fiber PHY link up
  input  wire logic        fiber_middle_link_i,           // Middle fiber PHY link up
  input  wire logic        rear_copper_link_i,            // Rear copper PHY link up
  input  wire logic        fiber_lower_link_i,            // Lower fiber PHY link up
  input  wire logic        front_copper_link_i,           // Front copper PHY link up
  input  wire logic        front_onboard_network_port_i,  // Front onboard port link up
  input  wire logic [3:0]  avs_address_i,                 // Byte address
  input  wire logic        avs_read_i,                    // Read request
  input  wire logic        avs_write_i,                   // Write request
  input  wire logic [31:0] avs_writedata_i,               // Write data
  input  wire logic [3:0]  avs_byteenable_i,              // Byte lanes
  output logic      [31:0] avs_readdata_o,                // Read data
  output logic             avs_waitrequest_o,             // Stall
  output logic             station_bus_one_link_o,        // Station bus one link
  output logic             station_bus_two_fiber_link_o,  // Station bus two fiber link
  output logic             station_bus_two_copper_link_o, // Station bus two copper link
  output logic             process_bus_link_o,            // Process bus link
  output logic             front_panel_link_o,            // Front panel link
  output logic             evt_fwd_valid_o,               // Forwarded event pulse
  output logic      [2:0]  evt_fwd_link_o,                // Forwarded event link index
  output logic             evt_fwd_on_o                   // Forwarded event value
);
  logic [`ELM_NPIN-1:0]  pin_raw;
  logic [`ELM_NPIN-1:0]  pin_meta_r;
  logic [`ELM_NPIN-1:0]  pin_sync_r;
  elm_pkg::elm_links_t   link_nxt;
  elm_pkg::elm_links_t   link_r;
  elm_pkg::elm_links_t   chg;
  elm_pkg::elm_links_t   pend_r;
  elm_pkg::elm_links_t   pend_val_r;
  elm_pkg::elm_links_t   pend_clr;
  elm_pkg::elm_idx_t     sel;
  logic                  push;
  elm_pkg::elm_links_t   mask_r;
  elm_pkg::elm_bus_e     bus_r;
  elm_pkg::elm_bus_e     bus_nxt;
  logic                  req;
  logic                  take;
  logic [31:0]           rdata_r;
  logic                  fwd_valid_r;
  elm_pkg::elm_idx_t     fwd_link_r;
  logic                  fwd_on_r;

  elm_evt_if evt ();

  elm_event_log u_log (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .evt   (evt.log)
  );

  // Lowest pending link index is logged first
  function automatic elm_pkg::elm_idx_t first_pending(input elm_pkg::elm_links_t p);
    elm_pkg::elm_idx_t idx;
    idx = 3'h0;
    for (int i = `ELM_NLINK - 1; i >= 0; i--) begin
      if (p[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [31:0] read_word(input logic [3:0] addr,
                                            input elm_pkg::elm_links_t links,
                                            input elm_pkg::elm_links_t mask,
                                            input elm_pkg::elm_cnt_t cnt,
                                            input logic ovf,
                                            input logic empty,
                                            input elm_pkg::elm_evt_s head);
    logic [31:0] w;
    w = `ELM_WORD_RST;
    if (addr == `ELM_OFS_LINK) begin
      w[`ELM_NLINK-1:0] = links;
    end else if (addr == `ELM_OFS_MASK) begin
      w[`ELM_NLINK-1:0] = mask;
    end else if (addr == `ELM_OFS_EVST) begin
      w[`ELM_EVST_CNT_MSB:`ELM_EVST_CNT_LSB] = cnt;
      w[`ELM_EVST_OVF_BIT]                   = ovf;
    end else if (addr == `ELM_OFS_EVDT) begin
      // An empty list has no stored head, so the word reads as zero
      if (!empty) begin
        w[`ELM_EVDT_LNK_MSB:`ELM_EVDT_LNK_LSB] = head.link;
        w[`ELM_EVDT_ON_BIT]                    = head.on;
      end
      w[`ELM_EVDT_VLD_BIT]                   = !empty;
    end
    return w;
  endfunction

  // Pin synchroniser; the first stage feeds only the second
  assign pin_raw = {front_onboard_network_port_i, front_copper_link_i, fiber_lower_link_i,
                    rear_copper_link_i, fiber_middle_link_i, fiber_upper_link_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_r <= `ELM_PIN_RST;
      pin_sync_r <= `ELM_PIN_RST;
    end else if (ce_i) begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Link status mapping
  always_comb begin
    link_nxt             = `ELM_LINK_RST;
    link_nxt[`ELM_STN_ONE]     = pin_sync_r[`ELM_STN_ONE];
    link_nxt[`ELM_STN_TWO_FIB] = pin_sync_r[`ELM_STN_TWO_FIB];
    link_nxt[`ELM_STN_TWO_CU]  = pin_sync_r[`ELM_STN_TWO_CU];
    link_nxt[`ELM_PROC_BUS]    = pin_sync_r[`ELM_PROC_BUS];
    link_nxt[`ELM_FRONT] = pin_sync_r[`ELM_PIN_FRONT_CU] | pin_sync_r[`ELM_PIN_ONBOARD];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_r <= `ELM_LINK_RST;
    end else if (ce_i) begin
      link_r <= link_nxt;
    end
  end

  // The five link status outputs are these levels; forwarded events have their own
  assign station_bus_one_link_o        = link_r[`ELM_STN_ONE];
  assign station_bus_two_fiber_link_o  = link_r[`ELM_STN_TWO_FIB];
  assign station_bus_two_copper_link_o = link_r[`ELM_STN_TWO_CU];
  assign process_bus_link_o            = link_r[`ELM_PROC_BUS];
  assign front_panel_link_o            = link_r[`ELM_FRONT];

  // Change detection; several links can change in one cycle,
  // so each changed link waits in a pending bit, with its latest value, until it is offered to the list
  assign chg      = link_nxt ^ link_r;
  assign push     = |pend_r;
  assign sel      = first_pending(pend_r);
  assign pend_clr = push ? elm_pkg::elm_links_t'(5'h01 << sel) : `ELM_LINK_RST;

  // A new change wins over the clear of the same bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_r     <= `ELM_LINK_RST;
      pend_val_r <= `ELM_LINK_RST;
    end else if (ce_i) begin
      pend_r     <= chg | (pend_r & ~pend_clr);
      pend_val_r <= (chg & link_nxt) | (~chg & pend_val_r);
    end
  end

  assign evt.push           = push;
  assign evt.push_code.link = sel;
  assign evt.push_code.on   = pend_val_r[sel];

  // Forwarding to the supervisory side, gated per link by the mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fwd_valid_r <= 1'b0;
      fwd_link_r  <= 3'h0;
      fwd_on_r    <= 1'b0;
    end else if (ce_i) begin
      fwd_valid_r <= push && mask_r[sel];
      fwd_link_r  <= sel;
      fwd_on_r    <= pend_val_r[sel];
    end
  end

  assign evt_fwd_valid_o = fwd_valid_r;
  assign evt_fwd_link_o  = fwd_link_r;
  assign evt_fwd_on_o    = fwd_on_r;

  // Bus slave: with ce_i high every access takes exactly one wait cycle, which gives
  // read data a full cycle to settle from the registered word
  assign req  = avs_read_i || avs_write_i;
  assign take = ce_i && (bus_r == elm_pkg::ELM_BUS_ACK) && req;

  always_comb begin
    bus_nxt = bus_r;
    case (bus_r)
      elm_pkg::ELM_BUS_IDLE: begin
        if (req) begin
          bus_nxt = elm_pkg::ELM_BUS_ACK;
        end
      end
      elm_pkg::ELM_BUS_ACK: begin
        bus_nxt = elm_pkg::ELM_BUS_IDLE;
      end
      default: begin
        bus_nxt = elm_pkg::ELM_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_r <= elm_pkg::ELM_BUS_IDLE;
    end else if (ce_i) begin
      bus_r <= bus_nxt;
    end
  end

  // A low enable stretches the wait, so no write is lost while frozen
  assign avs_waitrequest_o = req && !take;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= `ELM_WORD_RST;
    end else if (ce_i && avs_read_i && bus_r == elm_pkg::ELM_BUS_IDLE) begin
      rdata_r <= read_word(avs_address_i, link_r, mask_r, evt.count,
                           evt.ovf, evt.empty, evt.head);
    end
  end

  assign avs_readdata_o = rdata_r;

  // Pop only what the latched word actually showed
  assign evt.pop = ce_i && take && avs_read_i && (avs_address_i == `ELM_OFS_EVDT)
                   && rdata_r[`ELM_EVDT_VLD_BIT];

  assign evt.ovf_clr = take && avs_write_i && (avs_address_i == `ELM_OFS_EVST)
                       && avs_byteenable_i[`ELM_BE_OVF] && avs_writedata_i[`ELM_EVST_OVF_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= `ELM_MASK_RST;
    end else if (ce_i && take && avs_write_i && avs_address_i == `ELM_OFS_MASK
                 && avs_byteenable_i[`ELM_BE_MASK]) begin
      mask_r <= avs_writedata_i[`ELM_NLINK-1:0];
    end
  end

  property p_stn_one;
    @(posedge clk_i) disable iff (rst_i)
    ce_i |=> station_bus_one_link_o == $past(pin_sync_r[`ELM_STN_ONE]);
  endproperty
  a_stn_one: assert property (p_stn_one) else $error("station bus one wrong");

  property p_stn_two_fib;
    @(posedge clk_i) disable iff (rst_i)
    ce_i |=> station_bus_two_fiber_link_o == $past(pin_sync_r[`ELM_STN_TWO_FIB]);
  endproperty
  a_stn_two_fib: assert property (p_stn_two_fib) else $error("station bus two fiber wrong");

  property p_stn_two_cu;
    @(posedge clk_i) disable iff (rst_i)
    ce_i |=> station_bus_two_copper_link_o == $past(pin_sync_r[`ELM_STN_TWO_CU]);
  endproperty
  a_stn_two_cu: assert property (p_stn_two_cu) else $error("station bus two copper wrong");

  property p_proc_bus;
    @(posedge clk_i) disable iff (rst_i)
    ce_i |=> process_bus_link_o == $past(pin_sync_r[`ELM_PROC_BUS]);
  endproperty
  a_proc_bus: assert property (p_proc_bus) else $error("process bus wrong");

  property p_front;
    @(posedge clk_i) disable iff (rst_i)
    ce_i |=> front_panel_link_o == ($past(pin_sync_r[`ELM_PIN_FRONT_CU])
                                    || $past(pin_sync_r[`ELM_PIN_ONBOARD]));
  endproperty
  a_front: assert property (p_front) else $error("front link wrong");

  property p_fwd;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && push && mask_r[sel]) |=> evt_fwd_valid_o && evt_fwd_link_o == $past(sel);
  endproperty
  a_fwd: assert property (p_fwd) else $error("masked event not forwarded");

  property p_status;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && avs_read_i && bus_r == elm_pkg::ELM_BUS_IDLE && avs_address_i == `ELM_OFS_LINK)
    |=> avs_readdata_o[`ELM_NLINK-1:0] == $past(link_r);
  endproperty
  a_status: assert property (p_status) else $error("status read mismatch");

  property p_frozen;
    @(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(link_r) && $stable(pend_r);
  endproperty
  a_frozen: assert property (p_frozen) else $error("state moved while disabled");

  property p_rise;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && link_nxt[`ELM_STN_ONE] && !link_r[`ELM_STN_ONE])
    |=> pend_r[`ELM_STN_ONE] && pend_val_r[`ELM_STN_ONE];
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge event lost");

  property p_no_spurious;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && chg == `ELM_LINK_RST && !push) |=> !push;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("event without change");
endmodule

// File: test/elm_phy_model.sv
// Partner model of the port PHYs: six link-up levels for the monitor.
// Assumes the bench states the wanted levels; each follows after lag_i + 1 cycles.
`timescale 1ns/1ps
module elm_phy_model (
  input  wire logic       clk_i,   // System clock
  input  wire logic [5:0] want_i,  // Wanted link levels
  input  wire logic [2:0] lag_i,   // Cycles of lag, slow or prompt PHY
  output logic      [5:0] link_o   // Link-up levels to the monitor
);
  logic [5:0] hist_r [0:7];

  // Links start down so the monitor's synchronisers never see unknowns
  initial begin
    for (int i = 0; i < 8; i++) begin
      hist_r[i] = 6'h00;
    end
  end

  // Lag may only change while levels are steady, so no glitch is made
  always @(posedge clk_i) begin
    hist_r[0] <= want_i;
    for (int i = 1; i < 8; i++) begin
      hist_r[i] <= hist_r[i-1];
    end
  end

  assign link_o = hist_r[lag_i];
endmodule

// File: test/elm_link_monitor_test.sv
// Self-checking bench for the link monitor with a PHY model on its pins.
// Assumes elm_pkg, elm_evt_if and the design files are compiled first.
`timescale 1ns/1ps
`include "elm_params.svh"
module elm_link_monitor_test;
  logic        clk_i            = 1'b0;
  logic        rst_i            = 1'b1;
  logic        ce_i             = 1'b1;
  logic [5:0]  want             = 6'h00;
  logic [2:0]  lag              = 3'h0;
  logic [3:0]  avs_address_i    = 4'h0;
  logic        avs_read_i       = 1'b0;
  logic        avs_write_i      = 1'b0;
  logic [31:0] avs_writedata_i  = 32'h0000_0000;
  logic [3:0]  avs_byteenable_i = 4'h0;
  logic [5:0]  link;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        stn1;
  logic        stn2f;
  logic        sb2c;
  logic        pbl;
  logic        fpl;
  logic        evt_fwd_valid_o;
  logic [2:0]  evt_fwd_link_o;
  logic        evt_fwd_on_o;
  logic [2:0]  fwd_link;
  logic        fwd_on;
  int          num_errors       = 0;
  int          samples_checked  = 0;
  int          cycles           = 0;
  int          fwd_seen         = 0;
  int          seed             = 32'hbe31;

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  elm_phy_model u_elm_phy_model (.clk_i(clk_i), .want_i(want), .lag_i(lag), .link_o(link));

  elm_link_monitor u_elm_link_monitor (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .fiber_upper_link_i(link[0]), .fiber_middle_link_i(link[1]),
    .rear_copper_link_i(link[2]), .fiber_lower_link_i(link[3]),
    .front_copper_link_i(link[4]), .front_onboard_network_port_i(link[5]),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .station_bus_one_link_o(stn1), .station_bus_two_fiber_link_o(stn2f),
    .station_bus_two_copper_link_o(sb2c), .process_bus_link_o(pbl),
    .front_panel_link_o(fpl), .evt_fwd_valid_o(evt_fwd_valid_o),
    .evt_fwd_link_o(evt_fwd_link_o), .evt_fwd_on_o(evt_fwd_on_o));

  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Counting pulses also catches a pulse that stands longer than one cycle
  always @(posedge clk_i) begin
    cycles++;
    if (evt_fwd_valid_o === 1'b1) begin
      fwd_seen++;
      fwd_link = evt_fwd_link_o;
      fwd_on   = evt_fwd_on_o;
    end
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i    <= a;
    avs_read_i       <= ~wr;
    avs_write_i      <= wr;
    avs_writedata_i  <= d;
    avs_byteenable_i <= be;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    q = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    chk("bus_answer", 32'h1, 32'(n < 50));
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0000_0000, 4'hf, q);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask

  function automatic logic [4:0] exp_links(input logic [5:0] p);
    return {p[4] | p[5], p[3], p[2], p[1], p[0]};
  endfunction

  function automatic logic [31:0] evt_word(input logic [2:0] idx, input logic on);
    return {1'b1, 27'h0, on, idx};
  endfunction

  initial begin
    logic [31:0] q;
    logic [4:0]  prev;
    logic [4:0]  now;
    int          total;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("links_rst", 32'h0, {27'h0, fpl, pbl, sb2c, stn2f, stn1});
    wr(`ELM_OFS_LINK, 32'h0000_001f, 4'hf);
    rd(`ELM_OFS_LINK, q);
    chk("link_status_ro", 32'h0, q);
    rd(4'h2, q);
    chk("unmapped", 32'h0, q);
    rd(`ELM_OFS_EVST, q);
    chk("evt_status_rst", 32'h0, q);
    rd(`ELM_OFS_MASK, q);
    chk("mask_rst", 32'h0, q);
    wr(`ELM_OFS_MASK, 32'h0000_001f, 4'h1);
    rd(`ELM_OFS_MASK, q);
    chk("mask", 32'h1f, q);
    want <= 6'h04;
    repeat (8) @(posedge clk_i);
    chk("fwd_count_on", 32'h1, 32'(fwd_seen));
    chk("fwd_on", 32'ha, {28'h0, fwd_on, fwd_link});
    chk("sb2_copper", 32'h1, {31'h0, sb2c});
    want <= 6'h00;
    repeat (8) @(posedge clk_i);
    chk("fwd_count_off", 32'h2, 32'(fwd_seen));
    chk("fwd_off", 32'h2, {28'h0, fwd_on, fwd_link});
    rd(`ELM_OFS_EVST, q);
    chk("evt_count", 32'h2, q);
    rd(`ELM_OFS_EVDT, q);
    chk("pop_on", evt_word(3'h2, 1'b1), q);
    rd(`ELM_OFS_EVDT, q);
    chk("pop_off", evt_word(3'h2, 1'b0), q);
    rd(`ELM_OFS_EVDT, q);
    chk("pop_empty", 32'h0, q);
    // Front port: overlapping copper and onboard links give one on and one off
    wr(`ELM_OFS_MASK, 32'h0000_0000, 4'h1);
    want <= 6'h10;
    repeat (8) @(posedge clk_i);
    want <= 6'h30;
    repeat (8) @(posedge clk_i);
    want <= 6'h20;
    repeat (8) @(posedge clk_i);
    chk("front_onboard", 32'h1, {31'h0, fpl});
    want <= 6'h00;
    repeat (8) @(posedge clk_i);
    chk("front_off", 32'h0, {31'h0, fpl});
    chk("fwd_masked", 32'h2, 32'(fwd_seen));
    rd(`ELM_OFS_EVST, q);
    chk("front_count", 32'h2, q);
    rd(`ELM_OFS_EVDT, q);
    chk("front_pop_on", evt_word(3'h4, 1'b1), q);
    rd(`ELM_OFS_EVDT, q);
    chk("front_pop_off", evt_word(3'h4, 1'b0), q);
    prev  = 5'h00;
    total = 0;
    for (int i = 0; i < 40; i++) begin
      lag  <= 3'($random(seed));
      want <= (i == 0) ? 6'h3f : (i == 1) ? 6'h00 : 6'($random(seed));
      repeat (14) @(posedge clk_i);
      now   = exp_links(want);
      total += $countones(now ^ prev);
      prev  = now;
      chk("stn1", {31'h0, now[0]}, {31'h0, stn1});
      chk("stn2f", {31'h0, now[1]}, {31'h0, stn2f});
      chk("stn2c", {31'h0, now[2]}, {31'h0, sb2c});
      chk("proc", {31'h0, now[3]}, {31'h0, pbl});
      chk("front", {31'h0, now[4]}, {31'h0, fpl});
      rd(`ELM_OFS_LINK, q);
      chk("link_status", {27'h0, now}, q);
    end
    rd(`ELM_OFS_EVST, q);
    chk("full_count", 32'h8, {28'h0, q[3:0]});
    chk("overflow", 32'(total > 8), {31'h0, q[8]});
    wr(`ELM_OFS_EVST, 32'h0000_0100, 4'h2);
    rd(`ELM_OFS_EVST, q);
    chk("ovf_clear", 32'h8, q);
    rd(`ELM_OFS_EVDT, q);
    chk("oldest", evt_word(3'h0, 1'b1), q);
    chk("fwd_none", 32'h2, 32'(fwd_seen));
    // Enable low freezes the links and stalls a read until it rises
    now  = (prev == 5'h1f) ? 5'h00 : 5'h1f;
    ce_i <= 1'b0;
    want <= {now[4], now};
    fork
      rd(`ELM_OFS_LINK, q);
      begin
        repeat (12) @(posedge clk_i);
        chk("frozen", {27'h0, prev}, {27'h0, fpl, pbl, sb2c, stn2f, stn1});
        ce_i <= 1'b1;
      end
    join
    chk("stall_read", {27'h0, prev}, q);
    repeat (8) @(posedge clk_i);
    chk("thawed", {27'h0, now}, {27'h0, fpl, pbl, sb2c, stn2f, stn1});
    rd(`ELM_OFS_EVST, q);
    chk("ovf_again", 32'h0000_0108, q);
    wrap_up();
  end
endmodule
